/* File: ebc_ctrl.sv */
// Purpose: Register front end and self-timed programming engine of a byte store
// Assumes: Single sys_clk; osc_tick is a one-cycle pulse per calibrated oscillator period
// Notes:   Engine state is cleared only by por_reset so a running job survives reset
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

// Contract
// - Byte store of 128, 256 or 512 bytes
// - Read stalls the processor four cycles
// - Programming start stalls processor two cycles
// - Mode zero: combined erase and write
// - Mode one: erase only
// - Mode two: write data only
// - Strobe bit reads busy until completion
// - No new access while programming runs
// - Running job completes through reset
// - Durations count calibrated oscillator ticks
// - Registers sit in the I/O space
// - Arm self-clears after four cycles; needed
// - 3.4 ms combined, 1.8 ms split; three reserved
// - Mode bits locked while busy
// - Ready interrupt is level while idle
module ebc_ctrl
#(
  parameter int unsigned DEPTH        = `EBC_DEPTH,
  parameter int unsigned AW           = $clog2(DEPTH),
  parameter int unsigned TICK_W       = `EBC_TICK_W,
  parameter int unsigned ATOMIC_TICKS = `EBC_T_ATOMIC_US * `EBC_OSC_KHZ / 1000,
  parameter int unsigned SPLIT_TICKS  = `EBC_T_SPLIT_US * `EBC_OSC_KHZ / 1000
)
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       por_reset,
  input  wire logic       osc_tick,
  input  wire logic       global_irq_en,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       cpu_stall,
  output var  logic       irq
);

  // ==================================================================
  // Elaboration checks
  generate
    if (!(DEPTH == 128 || DEPTH == 256 || DEPTH == 512) || AW != $clog2(DEPTH))
    begin : g_bad_depth
      $error("ebc_ctrl: depth must be 128, 256 or 512");
    end
    if (ATOMIC_TICKS < 2 || SPLIT_TICKS < 2 ||
        ATOMIC_TICKS >= 2**TICK_W || SPLIT_TICKS >= 2**TICK_W)
    begin : g_bad_ticks
      $error("ebc_ctrl: tick counts do not fit the counter");
    end
  endgenerate

  // ==================================================================
  // State
  typedef struct packed {
    logic [AW-1:0]        addr;
    logic [7:0]           data;
    logic                 rie;
    logic                 arm;
    logic [2:0]           arm_cnt;
    logic                 rd_pend;
    logic [2:0]           stall_cnt;
    logic                 stall;
    logic [`EBC_ST_W-1:0] status;
    logic [`EBC_ST_W-1:0] mask;
    logic [7:0]           rdata;
    logic                 irq;
  } ebc_ctl_s;

  typedef struct packed {
    ebc_pkg::ebc_eng_e    state;
    logic [1:0]           mode;
    logic [AW-1:0]        addr;
    logic [7:0]           data;
    logic [TICK_W-1:0]    cnt;
  } ebc_eng_s;

  ebc_ctl_s          ctl;
  ebc_ctl_s          next_ctl;
  ebc_eng_s          eng;
  ebc_eng_s          next_eng;
  logic [7:0]        mem_rdata;
  logic              mem_wr;
  logic [7:0]        mem_wdata;
  logic              busy;
  logic              wr_ctrl;
  logic              pe_req;
  logic              rd_req;
  logic              start;
  logic              rd_acc;
  logic              addr_refused;
  logic              refused;
  logic              done_ev;
  logic [1:0]        wr_mode;
  logic [15:0]       addr_full;
  logic [7:0]        ctrl_view;

  // ==================================================================
  // Decode helpers
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
    hit = addr == off;
  endfunction : hit

  function automatic logic [TICK_W-1:0] op_ticks(input logic [1:0] mode);
    op_ticks = (mode == `EBC_PM_ATOMIC) ? TICK_W'(ATOMIC_TICKS) : TICK_W'(SPLIT_TICKS);
  endfunction : op_ticks

  // ==================================================================
  // Request qualification
  always_comb
  begin
    busy         = eng.state != ebc_pkg::ENG_IDLE;
    wr_ctrl      = reg_wr && hit(reg_addr, `EBC_OFF_CTRL);
    wr_mode      = reg_wdata[`EBC_CTRL_PM_HI:`EBC_CTRL_PM_LO];
    pe_req       = wr_ctrl && reg_wdata[`EBC_CTRL_PE];
    rd_req       = wr_ctrl && reg_wdata[`EBC_CTRL_RD];
    // A strobe only counts inside a live arm window
    start        = pe_req && ctl.arm && !busy && wr_mode != `EBC_PM_RSVD;
    rd_acc       = rd_req && !busy;
    addr_refused = reg_wr && busy &&
                   (hit(reg_addr, `EBC_OFF_ADDRL) || hit(reg_addr, `EBC_OFF_ADDRH));
    refused      = (pe_req && !start) || (rd_req && busy) || addr_refused;
    done_ev      = eng.state == ebc_pkg::ENG_COMMIT;
    addr_full    = 16'(ctl.addr);
    mem_wr       = done_ev;
    mem_wdata    = (eng.mode == `EBC_PM_ERASE) ? `EBC_ERASED_BYTE : eng.data;
  end

  // ==================================================================
  // Register front end
  always_comb
  begin
    next_ctl         = ctl;
    next_ctl.rd_pend = rd_acc;
    ctrl_view        = `EBC_BYTE_ZERO;
    // Arm window runs down on its own
    if (ctl.arm)
    begin
      next_ctl.arm_cnt = ctl.arm_cnt - 3'h1;
      if (ctl.arm_cnt == 3'h1)
        next_ctl.arm = 1'b0;
    end
    if (wr_ctrl)
    begin
      next_ctl.rie = reg_wdata[`EBC_CTRL_RIE];
      // Read-modify-write keeps the bit at one; only a fresh set opens the window
      if (reg_wdata[`EBC_CTRL_MPE] && !ctl.arm)
      begin
        next_ctl.arm     = 1'b1;
        next_ctl.arm_cnt = `EBC_ARM_CYCLES;
      end
    end
    if (start)
    begin
      next_ctl.arm     = 1'b0;
      next_ctl.arm_cnt = 3'h0;
    end
    // Address is frozen while a job runs
    if (reg_wr && hit(reg_addr, `EBC_OFF_ADDRL) && !busy)
      next_ctl.addr = AW'({addr_full[15:8], reg_wdata});
    if (reg_wr && hit(reg_addr, `EBC_OFF_ADDRH) && !busy)
      next_ctl.addr = AW'({reg_wdata, addr_full[7:0]});
    if (reg_wr && hit(reg_addr, `EBC_OFF_DATA))
      next_ctl.data = reg_wdata;
    if (ctl.rd_pend)
      next_ctl.data = mem_rdata;
    // Processor stall
    if (ctl.stall_cnt != 3'h0)
      next_ctl.stall_cnt = ctl.stall_cnt - 3'h1;
    if (rd_acc)
      next_ctl.stall_cnt = `EBC_RD_STALL;
    else if (start)
      next_ctl.stall_cnt = `EBC_PE_STALL;
    next_ctl.stall = next_ctl.stall_cnt != 3'h0;
    // Sticky events; a set in the clearing cycle wins
    if (reg_wr && hit(reg_addr, `EBC_OFF_STATUS))
      next_ctl.status = ctl.status & ~reg_wdata[`EBC_ST_W-1:0];
    if (done_ev)
      next_ctl.status[`EBC_ST_DONE] = 1'b1;
    if (refused)
      next_ctl.status[`EBC_ST_REFUSED] = 1'b1;
    if (reg_wr && hit(reg_addr, `EBC_OFF_MASK))
      next_ctl.mask = reg_wdata[`EBC_ST_W-1:0];
    next_ctl.irq = (global_irq_en && next_ctl.rie &&
                    next_eng.state == ebc_pkg::ENG_IDLE) ||
                   (|(next_ctl.status & next_ctl.mask));
    // Read data stand for one cycle only
    ctrl_view[`EBC_CTRL_PM_HI:`EBC_CTRL_PM_LO] = eng.mode;
    ctrl_view[`EBC_CTRL_RIE]                   = ctl.rie;
    ctrl_view[`EBC_CTRL_MPE]                   = ctl.arm;
    ctrl_view[`EBC_CTRL_PE]                    = busy;
    next_ctl.rdata = `EBC_BYTE_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        `EBC_OFF_CTRL:   next_ctl.rdata = ctrl_view;
        `EBC_OFF_DATA:   next_ctl.rdata = ctl.data;
        `EBC_OFF_ADDRL:  next_ctl.rdata = addr_full[7:0];
        `EBC_OFF_ADDRH:  next_ctl.rdata = addr_full[15:8];
        `EBC_OFF_STATUS: next_ctl.rdata = 8'(ctl.status);
        `EBC_OFF_MASK:   next_ctl.rdata = 8'(ctl.mask);
        default:         next_ctl.rdata = `EBC_BYTE_ZERO;
      endcase
    end
  end

  // ==================================================================
  // Programming engine
  always_comb
  begin
    next_eng = eng;
    case (eng.state)
      ebc_pkg::ENG_IDLE:
      begin
        if (start)
        begin
          next_eng.state = ebc_pkg::ENG_RUN;
          next_eng.mode  = wr_mode;
          next_eng.addr  = ctl.addr;
          next_eng.data  = ctl.data;
          next_eng.cnt   = op_ticks(wr_mode);
        end
        else if (reset)
          next_eng.mode = `EBC_PM_ATOMIC;
        else if (wr_ctrl)
          next_eng.mode = wr_mode;
      end
      ebc_pkg::ENG_RUN:
      begin
        // Counts oscillator periods, not processor cycles
        if (osc_tick)
        begin
          next_eng.cnt = eng.cnt - TICK_W'(1);
          if (eng.cnt == TICK_W'(1))
            next_eng.state = ebc_pkg::ENG_COMMIT;
        end
      end
      ebc_pkg::ENG_COMMIT:
        next_eng.state = ebc_pkg::ENG_IDLE;
      default:
        next_eng.state = ebc_pkg::ENG_IDLE;
    endcase
  end

  // ==================================================================
  // Registers; the ordinary reset only returns an idle engine's mode to combined
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ctl <= `EBC_CTL_RST;
    else
      ctl <= next_ctl;
  end

  always_ff @(posedge sys_clk or posedge por_reset)
  begin
    if (por_reset)
      eng <= `EBC_CTL_RST;
    else
      eng <= next_eng;
  end

  assign reg_rdata = ctl.rdata;
  assign cpu_stall = ctl.stall;
  assign irq       = ctl.irq;

  // ==================================================================
  // Byte array
  ebc_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .sys_clk (sys_clk),
    .reset   (por_reset),
    .wr_en   (mem_wr),
    .wr_addr (eng.addr),
    .wr_data (mem_wdata),
    .rd_en   (rd_acc),
    .rd_addr (ctl.addr),
    .rd_data (mem_rdata)
  );

  // ==================================================================
  // Checks
  sequence s_arm_set;
    wr_ctrl && reg_wdata[`EBC_CTRL_MPE] && !ctl.arm && !start;
  endsequence

  sequence s_quiet4;
    (!reg_wr)[*4];
  endsequence

  arm_window_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_arm_set ##1 s_quiet4 |-> ctl.arm ##1 !ctl.arm)
    else $error("arm window not four cycles");

  no_arm_a: assert property (@(posedge sys_clk) disable iff (reset || por_reset)
    pe_req && !ctl.arm && !busy |=> !busy)
    else $error("strobe without arm started a job");

  read_stall_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_acc |=> cpu_stall [*4] ##1 (!cpu_stall || $past(reg_wr)))
    else $error("read stall not four cycles");

  prog_stall_a: assert property (@(posedge sys_clk) disable iff (reset)
    start |=> cpu_stall [*2] ##1 (!cpu_stall || $past(reg_wr)))
    else $error("program stall not two cycles");

  busy_flag_a: assert property (@(posedge sys_clk) disable iff (reset || por_reset)
    start |=> busy && (eng.cnt == op_ticks($past(wr_mode))))
    else $error("job did not start with its duration");

  busy_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_req && busy && !ctl.rd_pend |=> !ctl.rd_pend && ctl.data == $past(ctl.data))
    else $error("read while busy touched data");

  mode_lock_a: assert property (@(posedge sys_clk) disable iff (por_reset)
    busy && wr_ctrl |=> $stable(eng.mode))
    else $error("mode changed while busy");

  tick_count_a: assert property (@(posedge sys_clk) disable iff (por_reset)
    eng.state == ebc_pkg::ENG_RUN && !osc_tick |=> $stable(eng.cnt))
    else $error("duration counter moved without a tick");

  commit_data_a: assert property (@(posedge sys_clk) disable iff (por_reset)
    done_ev && eng.mode == `EBC_PM_WRITE |=> u_mem.cells[$past(eng.addr)] == $past(eng.data))
    else $error("wrong byte committed");

  reset_survive_a: assert property (@(posedge sys_clk) disable iff (por_reset)
    eng.state == ebc_pkg::ENG_RUN && reset && !osc_tick |=> eng.state == ebc_pkg::ENG_RUN)
    else $error("reset aborted a running job");

  ready_irq_a: assert property (@(posedge sys_clk) disable iff (reset || por_reset)
    !busy && !start && ctl.rie && !wr_ctrl && global_irq_en |=> irq)
    else $error("ready interrupt missing while idle");

endmodule : ebc_ctrl

`default_nettype wire

/* File: ebc_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the byte store controller
// Assumes: Short tick counts so each job lasts a few dozen cycles
// Notes:   Expected bytes and timings are worked out here, never read back from the design
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

module ebc_ctrl_tb_top;
  localparam int ATK  = 6;
  localparam int SPT  = 3;
  localparam int TDIV = 8;
  logic        sys_clk, reset, por_reset, global_irq_en, tick_en;
  logic        osc_tick, reg_wr, reg_rd, cpu_stall, irq;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, v, d;
  logic [8:0]  a;
  logic [1:0]  m;
  logic [15:0] n;
  int          n_mismatch, checks_done, seed, cyc;

  ebc_ctrl #(.DEPTH(512), .ATOMIC_TICKS(ATK), .SPLIT_TICKS(SPT)) ebc_ctrl_inst
  (
    .sys_clk(sys_clk), .reset(reset), .por_reset(por_reset), .osc_tick(osc_tick),
    .global_irq_en(global_irq_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .irq(irq)
  );
  ebc_host_model #(.TICK_DIV(TDIV)) ebc_host_model_inst
  (
    .sys_clk(sys_clk), .tick_en(tick_en), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .osc_tick(osc_tick)
  );

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // ==================================================================
  // Helpers
  task automatic wr(input logic [5:0] o, input logic [7:0] x);
    ebc_host_model_inst.wr(o, x);
  endtask : wr
  task automatic rd(input logic [5:0] o, output logic [7:0] x);
    ebc_host_model_inst.rd(o, x);
  endtask : rd
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic stall_len(output logic [15:0] k);
    k = 16'h0000;
    repeat (8)
    begin
      @(posedge sys_clk);
      if (cpu_stall === 1'b1) k = k + 16'h0001;
    end
  endtask : stall_len
  // Polls the busy bit; bounded so a stuck job cannot hang the run
  task automatic wait_idle(output int c);
    logic [7:0] x;
    x = 8'h02;
    c = 0;
    while (x[1] !== 1'b0 && c < 900)
    begin
      rd(`EBC_OFF_CTRL, x);
      c += 3;
    end
  endtask : wait_idle
  // Tick phase is unknown, so allow almost one tick period of slack
  function automatic logic [15:0] in_window(input int el, input int t);
    return (el > (t - 1) * TDIV && el <= t * TDIV + 12) ? 16'h0001 : 16'h0000;
  endfunction : in_window
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    seed = 32'hff4da298;
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    por_reset = 1'b1;
    global_irq_en = 1'b0;
    tick_en = 1'b1;
    a = 9'h000;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    por_reset <= 1'b0;
    for (int o = 26; o < 32; o++)
    begin
      rd(6'(o), v);
      cmp("reset value", 16'h0000, {8'h00, v});
    end
    cmp("irq after reset", 16'h0000, {15'h0000, irq});
    $display("test reset values done");

    for (int k = 0; k < 4; k++)
    begin
      m = (k == 3) ? 2'h0 : 2'(k);
      if (k != 2) a = (k == 3) ? 9'h1FF : 9'($random(seed));
      d = 8'($random(seed));
      ebc_host_model_inst.prog(a, d, m, 1'b0);
      stall_len(n);
      cmp("start stall", 16'h0002, n);
      rd(`EBC_OFF_CTRL, v);
      cmp("busy flag", 16'h0001, {15'h0000, v[1]});
      wait_idle(cyc);
      cmp("duration", 16'h0001, in_window(cyc + 11, (m == 2'h0) ? ATK : SPT));
      wr(`EBC_OFF_CTRL, 8'h01);
      stall_len(n);
      cmp("read stall", 16'h0004, n);
      rd(`EBC_OFF_DATA, v);
      cmp("stored byte", (m == 2'h1) ? 16'h00FF : 16'(d), 16'(v));
      rd(`EBC_OFF_STATUS, v);
      cmp("done status", 16'h0001, {8'h00, v});
      wr(`EBC_OFF_STATUS, 8'h01);
      rd(`EBC_OFF_STATUS, v);
      cmp("status cleared", 16'h0000, {8'h00, v});
    end
    $display("test program modes done");

    wr(`EBC_OFF_CTRL, 8'h04);
    rd(`EBC_OFF_CTRL, v);
    cmp("arm live", 16'h0001, {15'h0000, v[2]});
    repeat (5) @(posedge sys_clk);
    wr(`EBC_OFF_CTRL, 8'h02);
    rd(`EBC_OFF_CTRL, v);
    cmp("late strobe", 16'h0000, {8'h00, v});
    wr(`EBC_OFF_CTRL, 8'h34);
    wr(`EBC_OFF_CTRL, 8'h32);
    rd(`EBC_OFF_CTRL, v);
    cmp("reserved mode", 16'h0000, {15'h0000, v[1]});
    rd(`EBC_OFF_STATUS, v);
    cmp("refused status", 16'h0002, {8'h00, v});
    wr(`EBC_OFF_STATUS, 8'h02);
    $display("test refusals done");

    ebc_host_model_inst.prog(a, 8'hC3, 2'h0, 1'b0);
    wr(`EBC_OFF_ADDRL, ~a[7:0]);
    wr(`EBC_OFF_CTRL, 8'h32);
    wr(`EBC_OFF_CTRL, 8'h01);
    rd(`EBC_OFF_ADDRL, v);
    cmp("address locked", {8'h00, a[7:0]}, {8'h00, v});
    rd(`EBC_OFF_CTRL, v);
    cmp("mode locked", 16'h0002, {8'h00, v});
    rd(`EBC_OFF_DATA, v);
    cmp("data kept", 16'h00C3, {8'h00, v});
    wait_idle(cyc);
    rd(`EBC_OFF_STATUS, v);
    cmp("busy status", 16'h0003, {8'h00, v});
    wr(`EBC_OFF_STATUS, 8'h03);
    $display("test busy lockout done");

    tick_en <= 1'b0;
    ebc_host_model_inst.prog(a, 8'h96, 2'h0, 1'b0);
    repeat (3) @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rd(`EBC_OFF_CTRL, v);
    cmp("busy through reset", 16'h0001, {15'h0000, v[1]});
    tick_en <= 1'b1;
    wait_idle(cyc);
    wr(`EBC_OFF_ADDRL, a[7:0]);
    wr(`EBC_OFF_ADDRH, {7'h00, a[8]});
    wr(`EBC_OFF_CTRL, 8'h01);
    repeat (4) @(posedge sys_clk);
    rd(`EBC_OFF_DATA, v);
    cmp("job after reset", 16'h0096, {8'h00, v});
    wr(`EBC_OFF_STATUS, 8'h03);
    $display("test reset during job done");

    global_irq_en <= 1'b1;
    wr(`EBC_OFF_CTRL, 8'h08);
    repeat (2) @(posedge sys_clk);
    cmp("ready irq", 16'h0001, {15'h0000, irq});
    global_irq_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp("irq gated", 16'h0000, {15'h0000, irq});
    global_irq_en <= 1'b1;
    ebc_host_model_inst.prog(a, 8'h3C, 2'h0, 1'b1);
    repeat (2) @(posedge sys_clk);
    cmp("irq while busy", 16'h0000, {15'h0000, irq});
    wait_idle(cyc);
    repeat (2) @(posedge sys_clk);
    cmp("irq when ready", 16'h0001, {15'h0000, irq});
    global_irq_en <= 1'b0;
    wr(`EBC_OFF_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    cmp("masked done irq", 16'h0001, {15'h0000, irq});
    wr(`EBC_OFF_STATUS, 8'h01);
    repeat (2) @(posedge sys_clk);
    cmp("irq cleared", 16'h0000, {15'h0000, irq});
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule : ebc_ctrl_tb_top
`default_nettype wire

/* File: ebc_host_model.sv */
// Purpose: Processor side model driving the register port and the oscillator tick
// Assumes: Single sys_clk; strobes change just after a rising edge
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

module ebc_host_model
#(
  parameter int unsigned TICK_DIV = 8
)
(
  input  wire logic       sys_clk,
  input  wire logic       tick_en,
  input  wire logic [7:0] reg_rdata,
  output var  logic [5:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic       osc_tick
);
  logic [7:0] tick_cnt;

  initial
  begin
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    osc_tick  = 1'b0;
    tick_cnt  = 8'h00;
  end

  // ==================================================================
  // Calibrated oscillator stand-in; stops when tick_en is low
  always @(posedge sys_clk)
  begin
    tick_cnt <= (tick_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : tick_cnt + 8'h01;
    osc_tick <= tick_en && (tick_cnt == 8'(TICK_DIV - 1));
  end

  // ==================================================================
  // Register cycles
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // Load address and data first, then arm and strobe inside the window
  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
                      input logic rie);
    wr(`EBC_OFF_ADDRL, a[7:0]);
    wr(`EBC_OFF_ADDRH, {7'h00, a[8]});
    wr(`EBC_OFF_DATA, d);
    wr(`EBC_OFF_CTRL, {2'h0, m, rie, 3'h4});
    wr(`EBC_OFF_CTRL, {2'h0, m, rie, 3'h2});
  endtask : prog
endmodule : ebc_host_model
`default_nettype wire

/* File: ebc_mem.sv */
// Purpose: Byte array behind the controller with a registered read port
// Assumes: One write and one read port on the system clock
// Notes:   Array holds no reset; only the read register is cleared
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"

module ebc_mem
#(
  parameter int unsigned DEPTH = `EBC_DEPTH,
  parameter int unsigned AW    = $clog2(DEPTH)
)
(
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [7:0]    rd_data
);

  // ==================================================================
  // Storage
  logic [7:0] cells [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      cells[wr_addr] <= wr_data;
  end

  // ==================================================================
  // Read register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rd_data <= `EBC_BYTE_ZERO;
    else if (rd_en)
      rd_data <= cells[rd_addr];
  end

endmodule : ebc_mem

`default_nettype wire

/* File: ebc_pkg.sv */
// Purpose: Shared types of the byte store controller
// Assumes: Compiled before the design modules
// Notes:   Offsets and figures live in ebc_regs.svh
`default_nettype none

package ebc_pkg;

  // ==================================================================
  // Programming engine states
  typedef enum logic [1:0]
  {
    ENG_IDLE,
    ENG_RUN,
    ENG_COMMIT
  } ebc_eng_e;

endpackage : ebc_pkg

`default_nettype wire

/* File: ebc_regs.svh */
// Purpose: Register offsets, field positions and timing figures of the byte store controller
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Definitions only
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH

// ==================================================================
// Register offsets in the I/O space
`define EBC_OFF_STATUS   6'h1A
`define EBC_OFF_MASK     6'h1B
`define EBC_OFF_CTRL     6'h1C
`define EBC_OFF_DATA     6'h1D
`define EBC_OFF_ADDRL    6'h1E
`define EBC_OFF_ADDRH    6'h1F

// ==================================================================
// Control register fields
`define EBC_CTRL_RD      0
`define EBC_CTRL_PE      1
`define EBC_CTRL_MPE     2
`define EBC_CTRL_RIE     3
`define EBC_CTRL_PM_LO   4
`define EBC_CTRL_PM_HI   5

// Programming modes
`define EBC_PM_ATOMIC    2'h0
`define EBC_PM_ERASE     2'h1
`define EBC_PM_WRITE     2'h2
`define EBC_PM_RSVD      2'h3

// ==================================================================
// Status and mask fields
`define EBC_ST_W         2
`define EBC_ST_DONE      0
`define EBC_ST_REFUSED   1

// ==================================================================
// Reset values and contents
`define EBC_CTL_RST      '0
`define EBC_BYTE_ZERO    8'h00
`define EBC_ERASED_BYTE  8'hFF

// ==================================================================
// Timing
`define EBC_ARM_CYCLES   3'h4
`define EBC_RD_STALL     3'h4
`define EBC_PE_STALL     3'h2
`define EBC_T_ATOMIC_US  3400
`define EBC_T_SPLIT_US   1800
`define EBC_OSC_KHZ      10000
`define EBC_TICK_W       16
`define EBC_DEPTH        512

`endif
